// File: rtl/mft_pkg.sv
// Constants, register layouts and access codes for the multi-function timer.
// Assumes a single 250 MHz system clock and the mode-selected access port.
//
// Function
// RULE_01 - Capture one comes from port pin four.
// RULE_02 - Waveform output drives port pin six always. The code drives it in every mode except software mode.
// RULE_03 - Event clock comes from port pin seven.
// RULE_04 - Two 8-bit control registers per timer.
// RULE_05 - Interrupts from compare, capture, overflow only.
// RULE_06 - Control A bit order, flags and enables.
// RULE_07 - Capture edges set sticky capture flags.
// RULE_08 - Capture enable gates capture interrupt requests.
// RULE_09 - Compare matches set sticky compare flags.
// RULE_10 - Compare enable gates compare interrupt requests.
// RULE_11 - Overflow sets flag, only software clears.
// RULE_12 - Overflow enable gates overflow interrupt requests.
// RULE_13 - Control B bit seven ignored by timer.
// RULE_14 - Capture edge bit selects capture polarity.
// RULE_15 - Event edge bit selects event polarity.
// RULE_16 - Prescaler divides clock by power of two.
// RULE_17 - Mode field selects one of four modes.
// RULE_18 - PWM alternates compare targets, restarting count.
// RULE_19 - Software and event modes follow PWM.
// RULE_20 - Capture mode free runs, toggles, captures.
// RULE_21 - Counter resets to zero, wraps at max.
// RULE_22 - Interrupt when enabled flag is pending.
package mft_pkg;

  // ----------------------------------------------------------------
  // Control A field positions
  // ----------------------------------------------------------------
  localparam int CTLA_CAP2_FLAG = 7;
  localparam int CTLA_CAP1_FLAG = 6;
  localparam int CTLA_CAP_IE = 5;
  localparam int CTLA_CMP2_FLAG = 4;
  localparam int CTLA_CMP1_FLAG = 3;
  localparam int CTLA_CMP_IE = 2;
  localparam int CTLA_OVF_FLAG = 1;
  localparam int CTLA_OVF_IE = 0;

  // ----------------------------------------------------------------
  // Control B field positions
  // ----------------------------------------------------------------
  localparam int CTLB_SIDE_BIT = 7;
  localparam int CTLB_CAP_EDGE = 6;
  localparam int CTLB_EVT_EDGE = 5;
  localparam int CTLB_PS_HI = 4;
  localparam int CTLB_PS_LO = 2;
  localparam int CTLB_MODE_HI = 1;
  localparam int CTLB_MODE_LO = 0;

  // ----------------------------------------------------------------
  // Reset values and port pin positions
  // ----------------------------------------------------------------
  localparam logic [7:0] CTLA_RESET = 8'h00;
  localparam logic [7:0] CTLB_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] CMP_RESET = 16'h0000;
  localparam int PIN_CAP1 = 4;
  localparam int PIN_CAP2 = 5;
  localparam int PIN_WAVE = 6;
  localparam int PIN_EVENT = 7;

  // ----------------------------------------------------------------
  // Access codes placed in the mode selector
  // ----------------------------------------------------------------
  localparam logic [4:0] SEL_RD_CAP_LO = 5'h00;
  localparam logic [4:0] SEL_RD_CAP_HI = 5'h01;
  localparam logic [4:0] SEL_RD_CMP2_LO = 5'h02;
  localparam logic [4:0] SEL_RD_CMP2_HI = 5'h03;
  localparam logic [4:0] SEL_RD_CMP1_LO = 5'h04;
  localparam logic [4:0] SEL_RD_CMP1_HI = 5'h05;
  localparam logic [4:0] SEL_RD_CTLB = 5'h06;
  localparam logic [4:0] SEL_RD_CTLA = 5'h07;
  localparam logic [4:0] SEL_CLEAR = 5'h10;
  localparam logic [4:0] SEL_WR_CMP2_LO = 5'h12;
  localparam logic [4:0] SEL_WR_CMP2_HI = 5'h13;
  localparam logic [4:0] SEL_WR_CMP1_LO = 5'h14;
  localparam logic [4:0] SEL_WR_CMP1_HI = 5'h15;
  localparam logic [4:0] SEL_WR_CTLB = 5'h16;
  localparam logic [4:0] SEL_WR_CTLA = 5'h17;

  // ----------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_SOFT = 2'b00;
  localparam logic [1:0] MODE_PWM = 2'b01;
  localparam logic [1:0] MODE_CAPCMP = 2'b10;
  localparam logic [1:0] MODE_EVENT = 2'b11;

endpackage

// File: rtl/pin_edge_detect.sv
// Synchroniser and edge detector for one asynchronous port pin.
// Assumes the pin is slow compared to the system clock.
`timescale 1ns/100ps
module pin_edge_detect
(
  input wire logic clk,
  input wire logic rst,
  input wire logic pinIn,
  input wire logic risingSel,
  output logic edgePulse
);

  logic meta_q;
  logic sync_q;
  logic last_q;

  // Two flops bring the pin in; the edge logic compares the second with a third flop holding its last level.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end
    else
    begin
      meta_q <= pinIn;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // Polarity picks which transition counts as the valid edge.
  assign edgePulse = risingSel ? (sync_q & ~last_q) : (~sync_q & last_q);

endmodule // pin_edge_detect

// File: rtl/multi_function_timer_control.sv
// Multi-function 16-bit timer: control registers, counter, pins, interrupt.
// Assumes a CPU access port driven on clk and port pins that are asynchronous.
`timescale 1ns/100ps
module multi_function_timer_control
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] portBIn,
  input wire logic [4:0] accessSel,
  input wire logic accessWr,
  input wire logic accessRd,
  input wire logic [7:0] accessWrData,
  output logic [7:0] accessRdData,
  output logic waveformOut,
  output logic waveformOe,
  output logic sideConfigBit,
  output logic timerIrq
);
  import mft_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] ctlA_q;
  logic [7:0] ctlB_q;
  logic [15:0] count_q;
  logic [15:0] cmp1_q;
  logic [15:0] cmp2_q;
  logic [15:0] capture_q;
  logic [6:0] div_q;
  logic phase_q;
  logic wave_q;
  logic [7:0] rdData_q;

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  wire [1:0] modeField = ctlB_q[CTLB_MODE_HI:CTLB_MODE_LO];
  wire [2:0] prescalerField = ctlB_q[CTLB_PS_HI:CTLB_PS_LO];
  wire isCapCmp = (modeField == MODE_CAPCMP);
  wire isEvent = (modeField == MODE_EVENT);
  wire wrCtlA = accessWr && (accessSel == SEL_WR_CTLA);
  wire wrCtlB = accessWr && (accessSel == SEL_WR_CTLB);
  wire wrClear = accessWr && (accessSel == SEL_CLEAR);
  wire wrCmp1Lo = accessWr && (accessSel == SEL_WR_CMP1_LO);
  wire wrCmp1Hi = accessWr && (accessSel == SEL_WR_CMP1_HI);
  wire wrCmp2Lo = accessWr && (accessSel == SEL_WR_CMP2_LO);
  wire wrCmp2Hi = accessWr && (accessSel == SEL_WR_CMP2_HI);

  // ----------------------------------------------------------------
  // Pin edges
  // ----------------------------------------------------------------
  logic cap1Edge;
  logic cap2Edge;
  logic eventEdge;

  pin_edge_detect u_cap1 (
    .clk(clk), .rst(rst), .pinIn(portBIn[PIN_CAP1]), // [RULE_01]
    .risingSel(ctlB_q[CTLB_CAP_EDGE]), .edgePulse(cap1Edge) // [RULE_14]
  );
  pin_edge_detect u_cap2 (
    .clk(clk), .rst(rst), .pinIn(portBIn[PIN_CAP2]), // [RULE_01]
    .risingSel(ctlB_q[CTLB_CAP_EDGE]), .edgePulse(cap2Edge) // [RULE_14]
  );
  pin_edge_detect u_evt (
    .clk(clk), .rst(rst), .pinIn(portBIn[PIN_EVENT]), // [RULE_03]
    .risingSel(ctlB_q[CTLB_EVT_EDGE]), .edgePulse(eventEdge) // [RULE_15]
  );

  // ----------------------------------------------------------------
  // Timer tick: prescaled system clock or external event edge
  // ----------------------------------------------------------------
  // The divider is free running, so a prescaler change takes effect at
  // once, at the cost of one irregular first period.
  wire [6:0] divMask = 7'((8'h01 << prescalerField) - 8'h01); // [RULE_16]
  wire preTick = ((div_q & divMask) == divMask); // [RULE_16]
  wire tick = isEvent ? eventEdge : preTick; // [RULE_03] [RULE_19]

  // ----------------------------------------------------------------
  // Counter events
  // ----------------------------------------------------------------
  wire [15:0] target = phase_q ? cmp2_q : cmp1_q;
  wire pwmMatch = tick && !isCapCmp && (count_q == target); // [RULE_18]
  wire ccMatch = tick && isCapCmp && (count_q == cmp1_q); // [RULE_20]
  wire overflow = tick && !pwmMatch && (count_q == COUNT_MAX); // [RULE_21]
  wire setCmp1 = ccMatch || (pwmMatch && !phase_q); // [RULE_09]
  wire setCmp2 = pwmMatch && phase_q; // [RULE_09]
  wire setCap1 = isCapCmp && cap1Edge; // [RULE_07]
  wire setCap2 = isCapCmp && cap2Edge; // [RULE_07]

  // Flag next values: writing 0 clears, a hardware set beats the clear.
  wire [7:0] flagKeep = wrCtlA ? (ctlA_q & accessWrData) : ctlA_q;
  wire [7:0] ctlA_d = {
    setCap2 | flagKeep[CTLA_CAP2_FLAG], // [RULE_07]
    setCap1 | flagKeep[CTLA_CAP1_FLAG], // [RULE_07]
    wrCtlA ? accessWrData[CTLA_CAP_IE] : ctlA_q[CTLA_CAP_IE],
    setCmp2 | flagKeep[CTLA_CMP2_FLAG], // [RULE_09]
    setCmp1 | flagKeep[CTLA_CMP1_FLAG], // [RULE_09]
    wrCtlA ? accessWrData[CTLA_CMP_IE] : ctlA_q[CTLA_CMP_IE],
    overflow | flagKeep[CTLA_OVF_FLAG], // [RULE_11]
    wrCtlA ? accessWrData[CTLA_OVF_IE] : ctlA_q[CTLA_OVF_IE]
  }; // [RULE_04] [RULE_06]

  // Control registers; bit 7 of control B is only stored and exported.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctlA_q <= CTLA_RESET;
      ctlB_q <= CTLB_RESET;
      div_q <= 7'h00;
    end
    else
    begin
      ctlA_q <= ctlA_d;
      div_q <= div_q + 7'h01;
      if (wrCtlB)
      begin
        ctlB_q <= accessWrData; // [RULE_04] [RULE_13] [RULE_17]
      end
    end
  end

  // Compare values; a capture-two event loads compare two ahead of a write.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cmp1_q <= CMP_RESET;
      cmp2_q <= CMP_RESET;
      capture_q <= COUNT_RESET;
    end
    else
    begin
      if (wrCmp1Lo) cmp1_q[7:0] <= accessWrData;
      if (wrCmp1Hi) cmp1_q[15:8] <= accessWrData;
      if (setCap2) cmp2_q <= count_q; // [RULE_20]
      else if (wrCmp2Lo) cmp2_q[7:0] <= accessWrData;
      else if (wrCmp2Hi) cmp2_q[15:8] <= accessWrData;
      if (setCap1) capture_q <= count_q; // [RULE_20]
    end
  end

  // Counter, compare phase and waveform. Clear restarts at compare one.
  always_ff @(posedge clk)
  begin
    if (rst || wrClear)
    begin
      count_q <= COUNT_RESET; // [RULE_21]
      phase_q <= 1'b0;
      wave_q <= 1'b0;
    end
    else if (pwmMatch)
    begin
      count_q <= COUNT_RESET; // [RULE_18]
      phase_q <= ~phase_q;
      wave_q <= ~phase_q; // [RULE_18]
    end
    else if (tick)
    begin
      count_q <= count_q + 16'h0001; // [RULE_21]
      if (ccMatch) wave_q <= ~wave_q; // [RULE_20]
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [7:0] rdMux;
  always_comb
  begin
    case (accessSel)
      SEL_RD_CAP_LO: rdMux = capture_q[7:0];
      SEL_RD_CAP_HI: rdMux = capture_q[15:8];
      SEL_RD_CMP2_LO: rdMux = cmp2_q[7:0];
      SEL_RD_CMP2_HI: rdMux = cmp2_q[15:8];
      SEL_RD_CMP1_LO: rdMux = cmp1_q[7:0];
      SEL_RD_CMP1_HI: rdMux = cmp1_q[15:8];
      SEL_RD_CTLB: rdMux = ctlB_q;
      SEL_RD_CTLA: rdMux = ctlA_q;
      default: rdMux = 8'h00;
    endcase
  end

  // Read data is held until the next read strobe.
  always_ff @(posedge clk)
  begin
    if (rst) rdData_q <= 8'h00;
    else if (accessRd) rdData_q <= rdMux;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Only the software timer mode leaves the pin to the port logic; event mode
  // drives the waveform exactly as PWM mode does.
  assign waveformOut = wave_q; // [RULE_02]
  assign waveformOe = (modeField != MODE_SOFT); // [RULE_02] [RULE_19]
  assign sideConfigBit = ctlB_q[CTLB_SIDE_BIT]; // [RULE_13]
  assign accessRdData = rdData_q;
  assign timerIrq = // [RULE_05] [RULE_22]
    ((ctlA_q[CTLA_CAP2_FLAG] | ctlA_q[CTLA_CAP1_FLAG]) & ctlA_q[CTLA_CAP_IE]) | // [RULE_08]
    ((ctlA_q[CTLA_CMP2_FLAG] | ctlA_q[CTLA_CMP1_FLAG]) & ctlA_q[CTLA_CMP_IE]) | // [RULE_10]
    (ctlA_q[CTLA_OVF_FLAG] & ctlA_q[CTLA_OVF_IE]); // [RULE_12]

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_ovf_flag_set: assert property (@(posedge clk) disable iff (rst) // [RULE_11]
    overflow |=> ctlA_q[CTLA_OVF_FLAG] && count_q == COUNT_RESET)
    else $error("Overflow did not set flag or wrap counter.");
  chk_ovf_sticky: assert property (@(posedge clk) disable iff (rst) // [RULE_11]
    ctlA_q[CTLA_OVF_FLAG] && !wrCtlA |=> ctlA_q[CTLA_OVF_FLAG])
    else $error("Overflow flag dropped without a software write.");
  chk_cap1_load: assert property (@(posedge clk) disable iff (rst) // [RULE_20]
    setCap1 |=> capture_q == $past(count_q) && ctlA_q[CTLA_CAP1_FLAG])
    else $error("Capture one did not load register and flag.");
  chk_cap2_load: assert property (@(posedge clk) disable iff (rst) // [RULE_20]
    setCap2 |=> cmp2_q == $past(count_q) && ctlA_q[CTLA_CAP2_FLAG])
    else $error("Capture two did not load compare two and flag.");
  chk_cap_mode_only: assert property (@(posedge clk) disable iff (rst) // [RULE_07]
    !isCapCmp && !ctlA_q[CTLA_CAP2_FLAG] && !(wrCtlA && accessWrData[CTLA_CAP2_FLAG])
    |=> !ctlA_q[CTLA_CAP2_FLAG])
    else $error("Capture flag set outside capture mode.");
  chk_pwm_restart: assert property (@(posedge clk) disable iff (rst) // [RULE_18]
    pwmMatch && !wrClear |=> count_q == COUNT_RESET && wave_q == $past(!phase_q))
    else $error("PWM match did not restart counter or set level.");
  chk_cc_toggle: assert property (@(posedge clk) disable iff (rst) // [RULE_20]
    ccMatch && !wrClear |=> wave_q != $past(wave_q)
      && count_q == 16'($past(count_q) + 16'h0001))
    else $error("Compare match in capture mode misbehaved.");
  chk_irq_gate: assert property (@(posedge clk) disable iff (rst) // [RULE_22]
    timerIrq == |(ctlA_q & {{2{ctlA_q[CTLA_CAP_IE]}}, 1'b0, {2{ctlA_q[CTLA_CMP_IE]}}, 1'b0,
      ctlA_q[CTLA_OVF_IE], 1'b0}))
    else $error("Interrupt output disagrees with flags and enables.");
  chk_side_bit_kept: assert property (@(posedge clk) disable iff (rst) // [RULE_13]
    !wrCtlB |=> sideConfigBit == $past(sideConfigBit))
    else $error("Control B bit seven changed without a write.");
  chk_div_tick: assert property (@(posedge clk) disable iff (rst) // [RULE_16]
    !isEvent && !wrCtlB && prescalerField == 3'b001 && $stable(prescalerField) && tick
    |=> !tick)
    else $error("Divide-by-two tick fired on consecutive cycles.");

endmodule // multi_function_timer_control

// File: tb/pin_source_model.sv
// Model of the external capture and event signal sources on port B.
// Assumes pulse() is called from a bench process just after a clk edge.
`timescale 1ns/100ps
module pin_source_model
(
  input wire logic clk,
  output logic [7:0] pinLevel
);
  // Pins rest low; a pulse holds three clocks high and three low,
  // above the two-clock minimum that the synchronisers need.
  initial pinLevel = 8'h00;
  task automatic pulse(input int idx);
    pinLevel[idx] = 1'b1;
    repeat (3) @(posedge clk);
    #1 pinLevel[idx] = 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask
endmodule // pin_source_model

// File: tb/multi_function_timer_control_tb_top.sv
// Self-checking bench for the multi-function timer control block.
// Assumes the pin model above and a 250 MHz clock.
`timescale 1ns/100ps
module multi_function_timer_control_tb_top;
  import mft_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] accessSel = 5'h00;
  logic accessWr = 1'b0;
  logic accessRd = 1'b0;
  logic [7:0] accessWrData = 8'h00;
  logic [7:0] accessRdData;
  logic waveformOut;
  logic waveformOe;
  logic sideConfigBit;
  logic timerIrq;
  logic [7:0] pinLevel;
  logic [7:0] portBIn;
  int mismatches = 0;
  int comparisons = 0;

  // ----------------------------------------------------------------
  // Clock, pins and the design
  // ----------------------------------------------------------------
  always #2 clk = ~clk;
  // The output pin reads back the driven level while the timer owns it.
  assign portBIn = {pinLevel[7], waveformOe ? waveformOut : pinLevel[6], pinLevel[5:0]};
  pin_source_model u_pins (.clk(clk), .pinLevel(pinLevel));
  multi_function_timer_control u_dut (.clk(clk), .rst(rst), .portBIn(portBIn),
    .accessSel(accessSel), .accessWr(accessWr), .accessRd(accessRd),
    .accessWrData(accessWrData), .accessRdData(accessRdData),
    .waveformOut(waveformOut), .waveformOe(waveformOe),
    .sideConfigBit(sideConfigBit), .timerIrq(timerIrq));

  // ----------------------------------------------------------------
  // Access and compare helpers
  // ----------------------------------------------------------------
  task automatic wr(input logic [4:0] sel, input logic [7:0] data);
    accessSel = sel;
    accessWrData = data;
    accessWr = 1'b1;
    @(posedge clk);
    #1 accessWr = 1'b0;
    // One idle edge, so that a following call never re-raises the strobe at once.
    @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [4:0] sel, output logic [7:0] data);
    accessSel = sel;
    accessRd = 1'b1;
    @(posedge clk);
    #1 accessRd = 1'b0;
    data = accessRdData;
    @(posedge clk);
    #1;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chkBit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: level %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic chkLen(input int got, input int exp);
    comparisons++;
    if (got != exp)
    begin
      mismatches++;
      $display("Error at %0t: %0d cycles, expected %0d", $time, got, exp);
    end
  endtask
  task automatic rdChk(input logic [4:0] sel, input logic [7:0] exp);
    logic [7:0] d;
    rd(sel, d);
    chk8(d, exp);
  endtask
  // Counts clocks while the waveform holds a level, bounded against a hang.
  task automatic holdLen(input logic lvl, output int n);
    n = 0;
    while (waveformOut === lvl && n < 20000)
    begin
      @(posedge clk);
      #1 n++;
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic testRegs();
    rdChk(SEL_RD_CTLA, 8'h00);
    rdChk(SEL_RD_CTLB, 8'h00);
    rdChk(SEL_RD_CAP_LO, 8'h00);
    rdChk(5'h08, 8'h00);
    // Both compare values reset to zero, so the soft-mode counter matches on
    // every tick and both compare flags stand beside the written enables.
    wr(SEL_WR_CTLA, 8'hff);
    rdChk(SEL_RD_CTLA, 8'h3d);
    chkBit(timerIrq, 1'b1);
    wr(SEL_WR_CTLA, 8'h00);
    wr(SEL_WR_CTLB, 8'h80);
    chkBit(sideConfigBit, 1'b1);
    chkBit(waveformOe, 1'b0);
    rdChk(SEL_RD_CTLB, 8'h80);
    $display("test regs done");
  endtask

  task automatic testPwm(input logic [2:0] ps);
    int n;
    wr(SEL_WR_CMP1_LO, 8'h04);
    wr(SEL_WR_CMP1_HI, 8'h00);
    wr(SEL_WR_CMP2_LO, 8'h02);
    wr(SEL_WR_CMP2_HI, 8'h00);
    wr(SEL_WR_CTLB, {3'b000, ps, MODE_PWM});
    wr(SEL_CLEAR, 8'h00);
    wr(SEL_WR_CTLA, 8'h04);
    chkBit(waveformOe, 1'b1);
    holdLen(1'b1, n);
    holdLen(1'b0, n);
    holdLen(1'b1, n);
    chkLen(n, 3 << ps);
    holdLen(1'b0, n);
    chkLen(n, 5 << ps);
    rdChk(SEL_RD_CTLA, 8'h1c);
    chkBit(timerIrq, 1'b1);
    $display("test pwm done");
  endtask

  task automatic testCapture();
    wr(SEL_WR_CMP1_LO, 8'hff);
    wr(SEL_WR_CMP1_HI, 8'hff);
    wr(SEL_WR_CTLB, 8'h42);
    wr(SEL_CLEAR, 8'h00);
    wr(SEL_WR_CTLA, 8'h20);
    chkBit(timerIrq, 1'b0);
    u_pins.pulse(PIN_CAP1);
    rdChk(SEL_RD_CTLA, 8'h60);
    chkBit(timerIrq, 1'b1);
    wr(SEL_WR_CTLB, 8'h02);
    wr(SEL_WR_CTLA, 8'h20);
    u_pins.pulse(PIN_CAP2);
    rdChk(SEL_RD_CTLA, 8'ha0);
    $display("test capture done");
  endtask

  task automatic testOverflow();
    int n;
    wr(SEL_WR_CTLA, 8'h01);
    n = 0;
    while (timerIrq !== 1'b1 && n < 70000)
    begin
      @(posedge clk);
      #1 n++;
    end
    rdChk(SEL_RD_CTLA, 8'h0b);
    chkBit(waveformOut, 1'b1);
    wr(SEL_WR_CTLA, 8'h02);
    chkBit(timerIrq, 1'b0);
    rdChk(SEL_RD_CTLA, 8'h02);
    $display("test overflow done");
  endtask

  task automatic testEvent();
    wr(SEL_WR_CMP1_LO, 8'h02);
    wr(SEL_WR_CMP1_HI, 8'h00);
    wr(SEL_WR_CTLB, 8'h23);
    wr(SEL_CLEAR, 8'h00);
    wr(SEL_WR_CTLA, 8'h04);
    chkBit(waveformOe, 1'b1);
    u_pins.pulse(PIN_EVENT);
    u_pins.pulse(PIN_EVENT);
    chkBit(timerIrq, 1'b0);
    u_pins.pulse(PIN_EVENT);
    rdChk(SEL_RD_CTLA, 8'h0c);
    chkBit(waveformOut, 1'b1);
    $display("test event done");
  endtask

  // ----------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    testRegs();
    testPwm(3'd0);
    testPwm(3'd1);
    testPwm(3'd2);
    testPwm(3'd7);
    testCapture();
    testOverflow();
    testEvent();
    summarize();
  end

  // The longest test waits out one full counter wrap of 65536 clocks; the
  // whole run needs about 68000, so this leaves a wide margin.
  initial
  begin
    repeat (95000) @(posedge clk);
    mismatches++;
    summarize();
  end
endmodule // multi_function_timer_control_tb_top
